// file: dv/fgr_link_chk.sv
// Checker for the command link between the two refresh ends
`timescale 1ns/10ps
module fgr_link_chk (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Link signals
	input wire logic cmd_mrs,
	input wire logic [2:0] cmd_mode,
	input wire logic cmd_tcr,
	input wire logic cmd_ref,
	input wire logic cmd_bg0,
	input wire logic cmd_sre,
	input wire logic cmd_srx,
	input wire logic dev_busy,
	input wire logic dev_err
);
	// Fast refresh: fixed fast mode, or on-the-fly with select high
	logic fast_ref;
	assign fast_ref = cmd_ref && (cmd_mode[1:0] != 2'h0) && (!cmd_mode[2] || cmd_bg0);

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	ref_normal_a: assert property (cmd_ref && !fast_ref |=> dev_busy [*6] ##1 !dev_busy)
		else $error("Normal refresh busy span wrong");
	ref_double_a: assert property (fast_ref && cmd_mode[0] |=> dev_busy [*5] ##1 !dev_busy)
		else $error("Double refresh busy span wrong");
	ref_quad_a: assert property (fast_ref && cmd_mode[1] |=> dev_busy [*3] ##1 !dev_busy)
		else $error("Quad refresh busy span wrong");
	busy_quiet_a: assert property (dev_busy |-> !(cmd_ref || cmd_mrs || cmd_sre || cmd_srx))
		else $error("Command sent inside refresh cycle");
	mode_legal_a: assert property (cmd_mrs |-> cmd_mode inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6})
		else $error("Reserved rate mode sent");
	tcr_normal_a: assert property (cmd_tcr |-> cmd_mode == 3'h0)
		else $error("Temperature refresh with fast mode");
	mode_hold_a: assert property ($changed(cmd_mode) |-> cmd_mrs || $past(cmd_mrs))
		else $error("Mode moved without mode write");
	one_cmd_a: assert property ($onehot0({cmd_mrs, cmd_ref, cmd_sre, cmd_srx}))
		else $error("Two commands in one cycle");
	no_error_a: assert property (!dev_err)
		else $error("Device saw illegal sequence");
endmodule // fgr_link_chk

// file: dv/test_fine_granularity_refresh.sv
// Self-checking bench for the refresh controller and DRAM end pair
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module test_fine_granularity_refresh;
	// Clock, reset and APB stimulus
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	// Design outputs
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [2:0] mode_o;
	logic [2:0] owed_o;
	logic tcr_o;
	logic self_refresh_o;
	logic [1:0] last_rate_o;
	// Bookkeeping
	int fails = 0;
	int num_checks = 0;
	integer seed = 32'hc14f;
	logic [1:0] band = 2'h0; // Temperature band for CTRL writes
	logic [31:0] rnd;
	logic [64:0] notes[$]; // Mask, error flag, data
	logic [64:0] nt;
	logic [2:0] rsv[3] = '{3'h3, 3'h4, 3'h7}; // Reserved codes

	fgr_link_if link ();
	fgr_ctrl_end #(.ADDR_W(8)) i_fgr_ctrl_end (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .link(link));
	fgr_dram_end i_fgr_dram_end (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .link(link), .mode_o(mode_o),
		.tcr_o(tcr_o), .last_rate_o(last_rate_o), .self_refresh_o(self_refresh_o), .owed_o(owed_o));
	fgr_link_chk i_fgr_link_chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .cmd_mrs(link.cmd_mrs),
		.cmd_mode(link.cmd_mode), .cmd_tcr(link.cmd_tcr), .cmd_ref(link.cmd_ref), .cmd_bg0(link.cmd_bg0),
		.cmd_sre(link.cmd_sre), .cmd_srx(link.cmd_srx), .dev_busy(link.dev_busy), .dev_err(link.dev_err));

	// Clock of 50 ns
	always #25 sys_clk_i = ~sys_clk_i;

	// Ends the run with the verdict
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// One APB transfer, noting the answer it must get
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		notes.push_back({m, a > 8'h0C, d});
		@(posedge sys_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		do @(posedge sys_clk_i); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, 32'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		xfer(1'b0, a, e, m);
	endtask
	// Program CTRL with mode and temperature flag
	task automatic ctl(input logic [2:0] m, input logic t);
		wr(fgr_pkg::OFS_CTRL, {26'h0, band, t, m});
	endtask
	// Command, then refusal flag check and clear
	task automatic cmd(input logic [4:0] c, input logic r);
		wr(fgr_pkg::OFS_CMD, {27'h0, c});
		rd(fgr_pkg::OFS_STATUS, {29'h0, r, 2'h0}, 32'h4);
		if (r) wr(fgr_pkg::OFS_STATUS, 32'h4);
		repeat (8) @(posedge sys_clk_i);
	endtask
	// Refresh, then interval reload check; low bits absorb the countdown
	task automatic refi(input logic [4:0] c, input int k);
		wr(fgr_pkg::OFS_CMD, {27'h0, c});
		rd(fgr_pkg::OFS_INTERVAL, 32'((fgr_pkg::BASE_INTERVAL_NS >> k) / fgr_pkg::CLK_PERIOD_NS), 32'hFC);
		repeat (8) @(posedge sys_clk_i);
	endtask

	// Monitor: each completed transfer takes the oldest note
	always @(posedge sys_clk_i) begin
		if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
			nt = notes.pop_front();
			`CHK("pslverr", nt[32], pslverr)
			`CHK("prdata", nt[31:0] & nt[64:33], prdata & nt[64:33])
		end
	end

	// Watchdog
	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fails++;
		wrap_up();
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(fgr_pkg::OFS_STATUS, 32'h0, 32'h1FFF);
		rd(fgr_pkg::OFS_INTERVAL, 32'h0, 32'hFF);
		rd(fgr_pkg::OFS_CMD, 32'h0, 32'hFFFFFFFF);
		rd(8'h10, 32'h0, 32'hFFFFFFFF);
		for (int i = 0; i < 4; i++) begin
			rnd = $random(seed);
			band = rnd[1:0];
			ctl(3'h0, 1'b0);
			rd(fgr_pkg::OFS_CTRL, {26'h0, band, 4'h0}, 32'h3F);
		end
		// Normal rate, hottest band, interval and due
		band = 2'h3;
		ctl(3'h0, 1'b0);
		refi(5'h2, 3);
		rd(fgr_pkg::OFS_STATUS, 32'h0, 32'h8);
		repeat (10) @(posedge sys_clk_i);
		rd(fgr_pkg::OFS_STATUS, 32'h8, 32'h8);
		`CHK("last_rate", 2'h0, last_rate_o)
		// Back-to-back refreshes: second lands inside the cycle time
		wr(fgr_pkg::OFS_CMD, 32'h2);
		rd(fgr_pkg::OFS_STATUS, 32'h1, 32'h1);
		cmd(5'h2, 1'b1);
		rd(fgr_pkg::OFS_STATUS, 32'h0, 32'h4);
		cmd(5'h0, 1'b1);
		cmd(5'h4, 1'b1);
		cmd(5'h10, 1'b1);
		// Temperature-controlled refresh only with normal mode
		band = 2'h1;
		ctl(3'h1, 1'b1);
		cmd(5'h1, 1'b1);
		ctl(3'h0, 1'b1);
		cmd(5'h1, 1'b0);
		rd(fgr_pkg::OFS_STATUS, 32'h800, 32'h800);
		`CHK("tcr", 1'b1, tcr_o)
		ctl(3'h0, 1'b0);
		cmd(5'h1, 1'b0);
		foreach (rsv[i]) begin
			ctl(rsv[i], 1'b0);
			cmd(5'h1, 1'b1);
		end
		// Double rate family
		ctl(3'h1, 1'b0);
		cmd(5'h1, 1'b0);
		rd(fgr_pkg::OFS_STATUS, 32'h100, 32'h700);
		cmd(5'h2, 1'b1);
		refi(5'h4, 2);
		`CHK("last_rate", 2'h1, last_rate_o)
		ctl(3'h0, 1'b0);
		cmd(5'h1, 1'b1);
		ctl(3'h5, 1'b0);
		cmd(5'h1, 1'b0);
		cmd(5'h4, 1'b0);
		cmd(5'h2, 1'b0);
		cmd(5'h4, 1'b0);
		cmd(5'h2, 1'b1);
		cmd(5'h4, 1'b0);
		cmd(5'h2, 1'b0);
		cmd(5'h4, 1'b0);
		cmd(5'h8, 1'b0);
		rd(fgr_pkg::OFS_STATUS, 32'h22, 32'h72);
		cmd(5'h2, 1'b1);
		cmd(5'h10, 1'b0);
		cmd(5'h4, 1'b0);
		rd(fgr_pkg::OFS_STATUS, 32'h10, 32'h72);
		cmd(5'h4, 1'b0);
		`CHK("owed", 3'h0, owed_o)
		// Second reset in mid-run
		reset_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		rd(fgr_pkg::OFS_STATUS, 32'h0, 32'h1FFF);
		// Quad rate family with self refresh
		band = 2'h0;
		ctl(3'h6, 1'b0);
		cmd(5'h1, 1'b0);
		refi(5'h4, 2);
		`CHK("last_rate", 2'h2, last_rate_o)
		ctl(3'h0, 1'b0);
		cmd(5'h1, 1'b1);
		ctl(3'h6, 1'b0);
		cmd(5'h2, 1'b1);
		ctl(3'h2, 1'b0);
		cmd(5'h1, 1'b0);
		`CHK("mode", 3'h2, mode_o)
		cmd(5'h2, 1'b1);
		cmd(5'h8, 1'b0);
		rd(fgr_pkg::OFS_STATUS, 32'h42, 32'h72);
		`CHK("self_refresh", 1'b1, self_refresh_o)
		cmd(5'h10, 1'b0);
		for (int i = 0; i < 4; i++) cmd(5'h4, 1'b0);
		rd(fgr_pkg::OFS_STATUS, 32'h8, 32'h7A);
		// Extras leave the expired interval at zero
		rd(fgr_pkg::OFS_INTERVAL, 32'h0, 32'hFF);
		wrap_up();
	end
endmodule // test_fine_granularity_refresh

// file: rtl/fgr_ctrl_end.sv
// Controller end: APB registers, legal refresh sequencing, interval timer
`timescale 1ns/10ps
module fgr_ctrl_end #(
	parameter int ADDR_W = 8 // APB address width
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Link
	fgr_link_if.ctrl link
);
	// Width check
	if (ADDR_W < 8) begin : g_addr_check
		$error("ADDR_W must be at least 8");
	end

	logic [2:0] ctl_mode_reg, ctl_mode_next; // Requested rate mode
	logic ctl_tcr_reg, ctl_tcr_next; // Requested temperature-controlled refresh
	logic [1:0] band_reg, band_next; // Temperature band
	logic [2:0] mode_reg, mode_next; // Active rate mode
	logic tcr_reg, tcr_next; // Active temperature-controlled refresh
	logic [3:0] busy_reg, busy_next; // Cycle time left
	logic sr_reg, sr_next; // In self refresh
	logic refused_reg, refused_next; // Sticky refused flag
	logic due_reg, due_next; // Interval elapsed
	logic [7:0] ivl_reg, ivl_next; // Interval countdown
	logic [2:0] owed_reg, owed_next; // Post-exit extras owed
	logic [1:0] cnt_mrs_reg, cnt_mrs_next; // Fast refreshes since rate write
	logic [1:0] cnt_seg_reg, cnt_seg_next; // Fast refreshes since normal one
	logic [1:0] cnt_sr_reg, cnt_sr_next; // Fast refreshes since exit
	logic mrs_reg, mrs_next; // Link pulses
	logic ref_reg, ref_next;
	logic sre_reg, sre_next;
	logic srx_reg, srx_next;
	logic bg0_reg, bg0_next; // Rate select with refresh
	logic [31:0] rdata_reg, rdata_next; // APB read data
	logic ready_reg, ready_next; // APB ready
	logic err_reg, err_next; // APB slave error
	logic wr_fire; // Write takes effect
	logic cmd_wr; // Write to the command register
	logic [1:0] fam; // Family of the active mode
	logic [1:0] rr; // Rate of a refresh being issued
	logic ok; // Command is legal
	logic addr_hit; // Mapped address
	logic [7:0] ofs; // Low address byte

	// APB access phase and decode
	always_comb begin
		ofs = paddr_i[7:0];
		// Upper address bits by shift, so that ADDR_W of 8 needs no empty slice
		addr_hit = ((paddr_i >> 8) == '0) && (ofs == fgr_pkg::OFS_CTRL || ofs == fgr_pkg::OFS_CMD ||
			ofs == fgr_pkg::OFS_STATUS || ofs == fgr_pkg::OFS_INTERVAL);
		wr_fire = psel_i && penable_i && ready_reg && pwrite_i && addr_hit;
		cmd_wr = wr_fire && (ofs == fgr_pkg::OFS_CMD);
		ready_next = psel_i && !penable_i;
		err_next = psel_i && !penable_i && !addr_hit;
		rdata_next = 32'h0;
		if (psel_i && !penable_i && !pwrite_i) begin
			unique case (ofs)
				fgr_pkg::OFS_CTRL: begin
					rdata_next[fgr_pkg::CTRL_MODE_LSB +: 3] = ctl_mode_reg;
					rdata_next[fgr_pkg::CTRL_TCR_BIT] = ctl_tcr_reg;
					rdata_next[fgr_pkg::CTRL_BAND_LSB +: 2] = band_reg;
				end
				fgr_pkg::OFS_STATUS: begin
					rdata_next[fgr_pkg::ST_BUSY_BIT] = (busy_reg != 4'h0);
					rdata_next[fgr_pkg::ST_SR_BIT] = sr_reg;
					rdata_next[fgr_pkg::ST_REFUSED_BIT] = refused_reg;
					rdata_next[fgr_pkg::ST_DUE_BIT] = due_reg;
					rdata_next[fgr_pkg::ST_OWED_LSB +: 3] = owed_reg;
					rdata_next[fgr_pkg::ST_MODE_LSB +: 3] = mode_reg;
					rdata_next[fgr_pkg::ST_TCR_BIT] = tcr_reg;
					rdata_next[fgr_pkg::ST_DEV_ERR_BIT] = link.dev_err;
				end
				fgr_pkg::OFS_INTERVAL: rdata_next[7:0] = ivl_reg;
				default: rdata_next = 32'h0;
			endcase
		end
	end

	// Command sequencing and refresh bookkeeping
	always_comb begin
		ctl_mode_next = ctl_mode_reg;
		ctl_tcr_next = ctl_tcr_reg;
		band_next = band_reg;
		mode_next = mode_reg;
		tcr_next = tcr_reg;
		sr_next = sr_reg;
		owed_next = owed_reg;
		cnt_mrs_next = cnt_mrs_reg;
		cnt_seg_next = cnt_seg_reg;
		cnt_sr_next = cnt_sr_reg;
		refused_next = refused_reg;
		mrs_next = 1'b0;
		ref_next = 1'b0;
		sre_next = 1'b0;
		srx_next = 1'b0;
		bg0_next = bg0_reg;
		busy_next = (busy_reg != 4'h0) ? busy_reg - 4'h1 : 4'h0;
		ivl_next = (ivl_reg != 8'h0 && !sr_reg) ? ivl_reg - 8'h1 : ivl_reg;
		due_next = due_reg || (ivl_reg == 8'h1 && !sr_reg);
		fam = fgr_pkg::mode_family(mode_reg);
		rr = fgr_pkg::RATE_NORMAL;
		ok = (busy_reg == 4'h0);
		// Control register
		if (wr_fire && ofs == fgr_pkg::OFS_CTRL) begin
			ctl_mode_next = pwdata_i[fgr_pkg::CTRL_MODE_LSB +: 3];
			ctl_tcr_next = pwdata_i[fgr_pkg::CTRL_TCR_BIT];
			band_next = pwdata_i[fgr_pkg::CTRL_BAND_LSB +: 2];
		end
		// Write one clears refused
		if (wr_fire && ofs == fgr_pkg::OFS_STATUS && pwdata_i[fgr_pkg::ST_REFUSED_BIT]) refused_next = 1'b0;
		if (cmd_wr) begin
			if (pwdata_i[fgr_pkg::CMD_MRS_BIT]) begin
				// Rate mode write
				if (sr_reg || fgr_pkg::mode_reserved(ctl_mode_reg)) ok = 1'b0;
				if (ctl_tcr_reg && ctl_mode_reg != fgr_pkg::MODE_FIXED_1X) ok = 1'b0;
				if (fgr_pkg::mode_family(ctl_mode_reg) != fam &&
					!fgr_pkg::count_aligned(fam, cnt_mrs_reg)) ok = 1'b0;
				if (ok) begin
					mrs_next = 1'b1;
					mode_next = ctl_mode_reg;
					tcr_next = ctl_tcr_reg;
					if (fgr_pkg::mode_family(ctl_mode_reg) != fam) begin
						cnt_mrs_next = 2'h0;
						cnt_seg_next = 2'h0;
						cnt_sr_next = 2'h0;
					end
				end
			end else if (pwdata_i[fgr_pkg::CMD_REF_NORMAL_BIT] || pwdata_i[fgr_pkg::CMD_REF_FAST_BIT]) begin
				// Refresh of chosen rate
				rr = pwdata_i[fgr_pkg::CMD_REF_NORMAL_BIT] ? fgr_pkg::RATE_NORMAL : fam;
				if (sr_reg) ok = 1'b0;
				if (rr == fgr_pkg::RATE_NORMAL && fam != fgr_pkg::RATE_NORMAL && !mode_reg[2]) ok = 1'b0;
				if (pwdata_i[fgr_pkg::CMD_REF_NORMAL_BIT] == 1'b0 && fam == fgr_pkg::RATE_NORMAL) ok = 1'b0;
				if (rr == fgr_pkg::RATE_NORMAL && !fgr_pkg::count_aligned(fam, cnt_seg_reg)) ok = 1'b0;
				if (ok) begin
					ref_next = 1'b1;
					bg0_next = (rr != fgr_pkg::RATE_NORMAL);
					busy_next = fgr_pkg::cycle_time(rr);
					// Extras after exit leave the interval alone
					if (owed_reg == 3'h0) begin
						ivl_next = fgr_pkg::interval_cycles(rr, band_reg);
						due_next = 1'b0;
					end
					if (rr == fgr_pkg::RATE_NORMAL) begin
						cnt_seg_next = 2'h0;
						cnt_sr_next = 2'h0;
						owed_next = 3'h0;
					end else begin
						cnt_mrs_next = cnt_mrs_reg + 2'h1;
						cnt_seg_next = cnt_seg_reg + 2'h1;
						cnt_sr_next = cnt_sr_reg + 2'h1;
						if (owed_reg != 3'h0) owed_next = owed_reg - 3'h1;
					end
				end
			end else if (pwdata_i[fgr_pkg::CMD_SRE_BIT]) begin
				// Entry in any rate
				if (sr_reg) ok = 1'b0;
				if (ok) begin
					sre_next = 1'b1;
					sr_next = 1'b1;
					if (!fgr_pkg::count_aligned(fam, cnt_sr_reg)) begin
						owed_next = (fam == fgr_pkg::RATE_QUAD) ? 3'h4 : 3'h2;
					end
				end
			end else if (pwdata_i[fgr_pkg::CMD_SRX_BIT]) begin
				// Exit
				if (!sr_reg) ok = 1'b0;
				if (ok) begin
					srx_next = 1'b1;
					sr_next = 1'b0;
					cnt_sr_next = 2'h0;
				end
			end else begin
				ok = 1'b0;
			end
			// Refusal sets over a same-cycle clear
			if (!ok) refused_next = 1'b1;
		end
	end

	// Registers
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctl_mode_reg <= fgr_pkg::MODE_RESET;
			ctl_tcr_reg <= 1'b0;
			band_reg <= 2'h0;
			mode_reg <= fgr_pkg::MODE_RESET;
			tcr_reg <= 1'b0;
			busy_reg <= 4'h0;
			sr_reg <= 1'b0;
			refused_reg <= 1'b0;
			due_reg <= 1'b0;
			ivl_reg <= fgr_pkg::INTERVAL_RESET;
			owed_reg <= 3'h0;
			cnt_mrs_reg <= 2'h0;
			cnt_seg_reg <= 2'h0;
			cnt_sr_reg <= 2'h0;
			mrs_reg <= 1'b0;
			ref_reg <= 1'b0;
			sre_reg <= 1'b0;
			srx_reg <= 1'b0;
			bg0_reg <= 1'b0;
			rdata_reg <= 32'h0;
			ready_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			ctl_mode_reg <= ctl_mode_next;
			ctl_tcr_reg <= ctl_tcr_next;
			band_reg <= band_next;
			mode_reg <= mode_next;
			tcr_reg <= tcr_next;
			busy_reg <= busy_next;
			sr_reg <= sr_next;
			refused_reg <= refused_next;
			due_reg <= due_next;
			ivl_reg <= ivl_next;
			owed_reg <= owed_next;
			cnt_mrs_reg <= cnt_mrs_next;
			cnt_seg_reg <= cnt_seg_next;
			cnt_sr_reg <= cnt_sr_next;
			mrs_reg <= mrs_next;
			ref_reg <= ref_next;
			sre_reg <= sre_next;
			srx_reg <= srx_next;
			bg0_reg <= bg0_next;
			rdata_reg <= rdata_next;
			ready_reg <= ready_next;
			err_reg <= err_next;
		end
	end

	// Outputs from flops
	assign prdata_o = rdata_reg;
	assign pready_o = ready_reg;
	assign pslverr_o = err_reg;
	assign link.cmd_mrs = mrs_reg;
	assign link.cmd_mode = mode_reg;
	assign link.cmd_tcr = tcr_reg;
	assign link.cmd_ref = ref_reg;
	assign link.cmd_bg0 = bg0_reg;
	assign link.cmd_sre = sre_reg;
	assign link.cmd_srx = srx_reg;
endmodule // fgr_ctrl_end

// file: rtl/fgr_dram_end.sv
// DRAM end: refresh rate state, cycle timing and sequence checks
`timescale 1ns/10ps
module fgr_dram_end (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Link
	fgr_link_if.dram link,
	// Status
	output logic [2:0] mode_o,
	output logic tcr_o,
	output logic [1:0] last_rate_o,
	output logic self_refresh_o,
	output logic [2:0] owed_o
);
	logic [2:0] mode_reg, mode_next; // Programmed rate mode
	logic tcr_reg, tcr_next; // Temperature-controlled refresh
	logic [3:0] busy_cnt_reg, busy_cnt_next; // Cycle time left
	logic busy_reg, busy_next; // Busy flag to link
	logic [1:0] cnt_mrs_reg, cnt_mrs_next; // Fast refreshes since rate write
	logic [1:0] cnt_seg_reg, cnt_seg_next; // Fast refreshes since normal one
	logic [1:0] cnt_sr_reg, cnt_sr_next; // Fast refreshes since exit
	logic sr_reg, sr_next; // In self refresh
	logic [2:0] owed_reg, owed_next; // Extra fast refreshes owed
	logic [1:0] rate_reg, rate_next; // Rate of last refresh
	logic err_reg, err_next; // Sticky sequence error
	logic [1:0] fam; // Family of the current mode
	logic [1:0] rrate; // Rate of an incoming refresh

	// Next state from link commands
	always_comb begin
		mode_next = mode_reg;
		tcr_next = tcr_reg;
		cnt_mrs_next = cnt_mrs_reg;
		cnt_seg_next = cnt_seg_reg;
		cnt_sr_next = cnt_sr_reg;
		sr_next = sr_reg;
		owed_next = owed_reg;
		rate_next = rate_reg;
		err_next = err_reg;
		fam = fgr_pkg::mode_family(mode_reg);
		rrate = fgr_pkg::ref_rate(mode_reg, link.cmd_bg0);
		busy_cnt_next = (busy_cnt_reg != 4'h0) ? busy_cnt_reg - 4'h1 : 4'h0;
		if (link.cmd_mrs) begin
			// Mode write checks
			if (fgr_pkg::mode_reserved(link.cmd_mode) || sr_reg || busy_reg) err_next = 1'b1;
			if (link.cmd_tcr && link.cmd_mode != fgr_pkg::MODE_FIXED_1X) err_next = 1'b1;
			if (fgr_pkg::mode_family(link.cmd_mode) != fam) begin
				// Only a real rate change needs whole counts
				if (!fgr_pkg::count_aligned(fam, cnt_mrs_reg)) err_next = 1'b1;
				cnt_mrs_next = 2'h0;
				cnt_seg_next = 2'h0;
				cnt_sr_next = 2'h0;
			end
			mode_next = link.cmd_mode;
			tcr_next = link.cmd_tcr;
		end
		if (link.cmd_ref) begin
			if (sr_reg || busy_reg) err_next = 1'b1;
			busy_cnt_next = fgr_pkg::cycle_time(rrate) - 4'h1;
			rate_next = rrate;
			if (rrate == fgr_pkg::RATE_NORMAL) begin
				// Normal refresh closes a fast run
				if (!fgr_pkg::count_aligned(fam, cnt_seg_reg)) err_next = 1'b1;
				cnt_seg_next = 2'h0;
				cnt_sr_next = 2'h0;
				owed_next = 3'h0;
			end else begin
				cnt_mrs_next = cnt_mrs_reg + 2'h1;
				cnt_seg_next = cnt_seg_reg + 2'h1;
				cnt_sr_next = cnt_sr_reg + 2'h1;
				if (owed_reg != 3'h0) owed_next = owed_reg - 3'h1;
			end
		end
		if (link.cmd_sre) begin
			// Entry accepted whatever the count
			if (busy_reg) err_next = 1'b1;
			sr_next = 1'b1;
			if (!fgr_pkg::count_aligned(fam, cnt_sr_reg)) begin
				owed_next = (fam == fgr_pkg::RATE_QUAD) ? 3'h4 : 3'h2;
			end
		end
		if (link.cmd_srx) begin
			sr_next = 1'b0;
			cnt_sr_next = 2'h0;
		end
		busy_next = (busy_cnt_next != 4'h0);
	end

	// State registers
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			mode_reg <= fgr_pkg::MODE_RESET;
			tcr_reg <= 1'b0;
			busy_cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			cnt_mrs_reg <= 2'h0;
			cnt_seg_reg <= 2'h0;
			cnt_sr_reg <= 2'h0;
			sr_reg <= 1'b0;
			owed_reg <= 3'h0;
			rate_reg <= fgr_pkg::RATE_NORMAL;
			err_reg <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			tcr_reg <= tcr_next;
			busy_cnt_reg <= busy_cnt_next;
			busy_reg <= busy_next;
			cnt_mrs_reg <= cnt_mrs_next;
			cnt_seg_reg <= cnt_seg_next;
			cnt_sr_reg <= cnt_sr_next;
			sr_reg <= sr_next;
			owed_reg <= owed_next;
			rate_reg <= rate_next;
			err_reg <= err_next;
		end
	end

	// Outputs straight from flops
	assign link.dev_busy = busy_reg;
	assign link.dev_err = err_reg;
	assign mode_o = mode_reg;
	assign tcr_o = tcr_reg;
	assign last_rate_o = rate_reg;
	assign self_refresh_o = sr_reg;
	assign owed_o = owed_reg;
endmodule // fgr_dram_end

// file: rtl/fgr_link_if.sv
// Command link between refresh controller and DRAM end
`timescale 1ns/10ps
interface fgr_link_if;
	logic cmd_mrs; // Mode register write pulse
	logic [2:0] cmd_mode; // Rate mode code with the write
	logic cmd_tcr; // Temperature-controlled refresh with the write
	logic cmd_ref; // Refresh pulse
	logic cmd_bg0; // Rate select with the refresh
	logic cmd_sre; // Self refresh entry pulse
	logic cmd_srx; // Self refresh exit pulse
	logic dev_busy; // Device inside a refresh cycle
	logic dev_err; // Device saw an illegal sequence

	modport ctrl (output cmd_mrs, cmd_mode, cmd_tcr, cmd_ref, cmd_bg0, cmd_sre, cmd_srx,
		input dev_busy, dev_err);
	modport dram (input cmd_mrs, cmd_mode, cmd_tcr, cmd_ref, cmd_bg0, cmd_sre, cmd_srx,
		output dev_busy, dev_err);
endinterface

// file: rtl/fgr_pkg.sv
// Shared constants and helpers for the fine granularity refresh pair
// Behaviour
// - Rate mode code: 000/001/010 fixed, 101/110 on-the-fly
// - On-the-fly modes take bg0 per refresh: high is faster
// - Fixed modes issue only their own refresh rate
// - On-the-fly modes mix normal with double or quad
// - Double and quad intervals are base/2, base/4
// - Each hotter temperature band halves the interval again
// - Cycle times 350, 260, 160 ns block commands
// - New rate values apply from the change onward
// - Each refresh imposes its own rate's timing
// - Double-rate count even before rate-changing write
// - Even double-rate count between two normal refreshes
// - Quad-rate count multiple of four before change
// - Quad-rate multiple of four between normal refreshes
// - Fixed 1x free; same-rate fixed/on-the-fly switch allowed
// - Temperature-controlled refresh demands code 000
// - Self refresh entry accepted in any rate
// - Odd double count before entry owes extras
// - Non-multiple quad count before entry owes extras
// - Post-exit extras do not restart interval timing
// - Post-exit extras tracked apart from postponement
package fgr_pkg;
	// Rate mode codes
	localparam logic [2:0] MODE_FIXED_1X = 3'h0;
	localparam logic [2:0] MODE_FIXED_2X = 3'h1;
	localparam logic [2:0] MODE_FIXED_4X = 3'h2;
	localparam logic [2:0] MODE_OTF_1X2X = 3'h5;
	localparam logic [2:0] MODE_OTF_1X4X = 3'h6;
	// Refresh rate encodings, also the interval shift
	localparam logic [1:0] RATE_NORMAL = 2'h0;
	localparam logic [1:0] RATE_DOUBLE = 2'h1;
	localparam logic [1:0] RATE_QUAD = 2'h2;
	// Timing in its own units
	localparam int CLK_PERIOD_NS = 50;
	localparam int BASE_INTERVAL_NS = 7800;
	localparam int CYCLE_TIME_NORMAL_NS = 350;
	localparam int CYCLE_TIME_DOUBLE_NS = 260;
	localparam int CYCLE_TIME_QUAD_NS = 160;
	// Cycle counts, least times rounded up
	localparam logic [3:0] CYC_NORMAL = 4'((CYCLE_TIME_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] CYC_DOUBLE = 4'((CYCLE_TIME_DOUBLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] CYC_QUAD = 4'((CYCLE_TIME_QUAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	// Register offsets of the controller
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_INTERVAL = 8'h0C;
	// Field positions
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_TCR_BIT = 3;
	localparam int CTRL_BAND_LSB = 4;
	localparam int CMD_MRS_BIT = 0;
	localparam int CMD_REF_NORMAL_BIT = 1;
	localparam int CMD_REF_FAST_BIT = 2;
	localparam int CMD_SRE_BIT = 3;
	localparam int CMD_SRX_BIT = 4;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_SR_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_DUE_BIT = 3;
	localparam int ST_OWED_LSB = 4;
	localparam int ST_MODE_LSB = 8;
	localparam int ST_TCR_BIT = 11;
	localparam int ST_DEV_ERR_BIT = 12;
	// Values after reset
	localparam logic [2:0] MODE_RESET = MODE_FIXED_1X;
	localparam logic [7:0] INTERVAL_RESET = 8'h00;

	// Reserved codes
	function automatic logic mode_reserved(input logic [2:0] m);
		return !(m == MODE_FIXED_1X || m == MODE_FIXED_2X || m == MODE_FIXED_4X ||
			m == MODE_OTF_1X2X || m == MODE_OTF_1X4X);
	endfunction

	// Fast rate family of a mode
	function automatic logic [1:0] mode_family(input logic [2:0] m);
		logic [1:0] f;
		f = m[1:0];
		if (m == MODE_OTF_1X2X) f = RATE_DOUBLE;
		if (m == MODE_OTF_1X4X) f = RATE_QUAD;
		return f;
	endfunction

	// Rate of one refresh command
	function automatic logic [1:0] ref_rate(input logic [2:0] m, input logic bg0);
		logic [1:0] r;
		r = mode_family(m);
		if (m[2] && !bg0) r = RATE_NORMAL;
		return r;
	endfunction

	// Count of fast refreshes is whole
	function automatic logic count_aligned(input logic [1:0] fam, input logic [1:0] cnt);
		logic a;
		a = 1'b1;
		if (fam == RATE_DOUBLE) a = !cnt[0];
		if (fam == RATE_QUAD) a = (cnt == 2'h0);
		return a;
	endfunction

	// Refresh cycle time in clocks
	function automatic logic [3:0] cycle_time(input logic [1:0] r);
		logic [3:0] c;
		c = CYC_NORMAL;
		if (r == RATE_DOUBLE) c = CYC_DOUBLE;
		if (r == RATE_QUAD) c = CYC_QUAD;
		return c;
	endfunction

	// Average interval in clocks, rounded down
	function automatic logic [7:0] interval_cycles(input logic [1:0] r, input logic [1:0] band);
		int v;
		v = (BASE_INTERVAL_NS >> (int'(r) + int'(band))) / CLK_PERIOD_NS;
		if (v < 1) v = 1;
		return 8'(v);
	endfunction
endpackage
